// ==== sgdc_top.sv ====
/*
 * sgdc_top: chain byte counter of a scatter-gather dma engine with an
 * axi4-lite register slave and a 16-word fifo on the transfer path.
 * assumes: transfers arrive as byte counts on xfer_*; the fetch request
 * is taken by the descriptor fetcher outside.
 */
// The address map and register access over AXI4-Lite were chosen for this implementation.
module sgdc_top
	import sgdc_pkg::*;
#(
	parameter int FIFO_DEPTH = SGDC_FIFO_DEPTH
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [7:0]   s_axi_awaddr,
	input  wire logic         s_axi_awvalid,
	output logic              s_axi_awready,
	input  wire logic [31:0]  s_axi_wdata,
	input  wire logic [3:0]   s_axi_wstrb,
	input  wire logic         s_axi_wvalid,
	output logic              s_axi_wready,
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  wire logic         s_axi_bready,
	input  wire logic [7:0]   s_axi_araddr,
	input  wire logic         s_axi_arvalid,
	output logic              s_axi_arready,
	output logic [31:0]       s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  wire logic         s_axi_rready,
	input  wire sgdc_xfer_s   xfer_data,
	input  wire logic         xfer_valid,
	output logic              xfer_ready,
	output logic              fetch_req,
	output logic [63:0]       fetch_addr,
	input  wire logic         fetch_ack,
	output logic              dma_active,
	output logic              dma_dir_read,
	output logic              dma_chain
);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        aw_got;
		logic        w_got;
		logic [7:0]  aw_addr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [63:0] desc_ptr;
		logic [63:0] total;
		logic [63:0] remain;
		logic [63:0] fetch_ptr;
		logic        auto_restart;
		logic        dir_read;
		logic        chain;
		sgdc_state_e state;
		logic        fetch_req;
		logic        active;
	} sgdc_top_s;

	sgdc_top_s  st_q;
	sgdc_top_s  st_d;
	sgdc_xfer_s fifo_data;
	logic       fifo_valid;
	logic       fifo_ready;

	sgdc_fifo #(
		.WIDTH ($bits(sgdc_xfer_s)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.in_data   (xfer_data),
		.in_valid  (xfer_valid),
		.in_ready  (xfer_ready),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_ready)
	);

	// transfers drain only while running; in idle or fetching up to FIFO_DEPTH queue before the source stalls
	assign fifo_ready = (st_q.state == SGDC_RUN);

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[8*i +: 8] = nw[8*i +: 8];
		return r;
	endfunction

	logic [63:0] remain_sub;
	logic        hits_zero;
	logic        start_wr;
	logic        do_write;
	assign remain_sub = st_q.remain - 64'(fifo_data.bytes);
	assign hits_zero  = fifo_valid && fifo_ready && (fifo_data.bytes >= st_q.remain);
	assign do_write   = st_q.aw_got && st_q.w_got && !st_q.bvalid;
	assign start_wr   = do_write && st_q.aw_addr == SGDC_ADDR_CTRL && st_q.wstrb[3]
		&& st_q.wdata[SGDC_CTRL_START_BIT];

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		st_d = st_q;
		// write channels taken in either order
		if (s_axi_awvalid && st_q.awready) begin
			st_d.aw_got  = 1'b1;
			st_d.aw_addr = s_axi_awaddr;
			st_d.awready = 1'b0;
		end
		if (s_axi_wvalid && st_q.wready) begin
			st_d.w_got  = 1'b1;
			st_d.wdata  = s_axi_wdata;
			st_d.wstrb  = s_axi_wstrb;
			st_d.wready = 1'b0;
		end
		if (do_write) begin
			st_d.bvalid = 1'b1;
			st_d.bresp  = SGDC_RESP_OKAY;
			unique case (st_q.aw_addr)
				SGDC_ADDR_DESC_LO:
					st_d.desc_ptr[31:0] = merge(st_q.desc_ptr[31:0], st_q.wdata, st_q.wstrb);
				SGDC_ADDR_DESC_HI:
					st_d.desc_ptr[63:32] = merge(st_q.desc_ptr[63:32], st_q.wdata, st_q.wstrb);
				SGDC_ADDR_TOTAL_LO:
					st_d.total[31:0] = merge(st_q.total[31:0], st_q.wdata, st_q.wstrb);
				SGDC_ADDR_TOTAL_HI:
					st_d.total[63:32] = merge(st_q.total[63:32], st_q.wdata, st_q.wstrb);
				SGDC_ADDR_REMAIN_LO, SGDC_ADDR_REMAIN_HI, SGDC_ADDR_STATUS:
					st_d.bresp = SGDC_RESP_OKAY;
				SGDC_ADDR_CTRL: begin
					if (st_q.wstrb[0]) begin
						st_d.auto_restart = st_q.wdata[SGDC_CTRL_AUTO_BIT];
						st_d.dir_read     = st_q.wdata[SGDC_CTRL_DIR_BIT];
					end
					if (st_q.wstrb[2])
						st_d.chain = st_q.wdata[SGDC_CTRL_CHAIN_BIT];
				end
				default:
					st_d.bresp = SGDC_RESP_SLVERR;
			endcase
		end
		if (st_q.bvalid && s_axi_bready) begin
			st_d.bvalid  = 1'b0;
			st_d.aw_got  = 1'b0;
			st_d.w_got   = 1'b0;
			st_d.awready = 1'b1;
			st_d.wready  = 1'b1;
		end
		// read channel
		if (s_axi_arvalid && st_q.arready) begin
			st_d.arready = 1'b0;
			st_d.rvalid  = 1'b1;
			st_d.rresp   = SGDC_RESP_OKAY;
			unique case (s_axi_araddr)
				SGDC_ADDR_DESC_LO:   st_d.rdata = st_q.desc_ptr[31:0];
				SGDC_ADDR_DESC_HI:   st_d.rdata = st_q.desc_ptr[63:32];
				SGDC_ADDR_TOTAL_LO:  st_d.rdata = st_q.total[31:0];
				SGDC_ADDR_TOTAL_HI:  st_d.rdata = st_q.total[63:32];
				SGDC_ADDR_REMAIN_LO: st_d.rdata = st_q.remain[31:0];
				SGDC_ADDR_REMAIN_HI: st_d.rdata = st_q.remain[63:32];
				SGDC_ADDR_CTRL: begin
					st_d.rdata = SGDC_ZERO32;
					st_d.rdata[SGDC_CTRL_AUTO_BIT]  = st_q.auto_restart;
					st_d.rdata[SGDC_CTRL_DIR_BIT]   = st_q.dir_read;
					st_d.rdata[SGDC_CTRL_CHAIN_BIT] = st_q.chain;
				end
				SGDC_ADDR_STATUS:    st_d.rdata = {30'h0, st_q.state};
				default: begin
					st_d.rdata = SGDC_ZERO32;
					st_d.rresp = SGDC_RESP_SLVERR;
				end
			endcase
		end
		if (st_q.rvalid && s_axi_rready) begin
			st_d.rvalid  = 1'b0;
			st_d.arready = 1'b1;
		end
		// chain engine
		unique case (st_q.state)
			SGDC_IDLE:
				if (start_wr) begin
					st_d.remain    = st_d.total;
					st_d.fetch_ptr = st_d.desc_ptr;
					st_d.fetch_req = 1'b1;
					st_d.state     = SGDC_FETCH;
				end
			SGDC_FETCH:
				if (fetch_ack) begin
					st_d.fetch_req = 1'b0;
					st_d.state     = SGDC_RUN;
				end
			SGDC_RUN:
				if (hits_zero) begin
					st_d.remain    = st_q.total;
					st_d.fetch_ptr = st_q.desc_ptr;
					if (st_q.auto_restart) begin
						st_d.fetch_req = 1'b1;
						st_d.state     = SGDC_FETCH;
					end else begin
						st_d.state = SGDC_IDLE;
					end
				end else if (fifo_valid) begin
					st_d.remain = remain_sub;
				end
		endcase
		st_d.active = (st_d.state != SGDC_IDLE);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q         <= '0;
			st_q.awready <= 1'b1;
			st_q.wready  <= 1'b1;
			st_q.arready <= 1'b1;
			st_q.state   <= SGDC_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	assign s_axi_awready = st_q.awready;
	assign s_axi_wready  = st_q.wready;
	assign s_axi_bvalid  = st_q.bvalid;
	assign s_axi_bresp   = st_q.bresp;
	assign s_axi_arready = st_q.arready;
	assign s_axi_rvalid  = st_q.rvalid;
	assign s_axi_rdata   = st_q.rdata;
	assign s_axi_rresp   = st_q.rresp;
	assign fetch_req     = st_q.fetch_req;
	assign fetch_addr    = st_q.fetch_ptr;
	assign dma_active    = st_q.active;
	assign dma_dir_read  = st_q.dir_read;
	assign dma_chain     = st_q.chain;

	// ****************************************
	// checks
	// ****************************************
	property p_decrement;
		@(posedge aclk) disable iff (!aresetn)
		fifo_valid && fifo_ready && !hits_zero |=> st_q.remain == $past(remain_sub);
	endproperty
	a_decrement: assert property (p_decrement) else $error("count not decremented");

	property p_reload;
		@(posedge aclk) disable iff (!aresetn)
		hits_zero |=> st_q.remain == $past(st_q.total) && st_q.fetch_ptr == $past(st_q.desc_ptr);
	endproperty
	a_reload: assert property (p_reload) else $error("no reload at zero");

	property p_auto_on;
		@(posedge aclk) disable iff (!aresetn)
		hits_zero && st_q.auto_restart |=> fetch_req && st_q.state == SGDC_FETCH;
	endproperty
	a_auto_on: assert property (p_auto_on) else $error("no restart");

	property p_auto_off;
		@(posedge aclk) disable iff (!aresetn)
		hits_zero && !st_q.auto_restart |=> !fetch_req && !dma_active;
	endproperty
	a_auto_off: assert property (p_auto_off) else $error("restarted while off");

	property p_start;
		@(posedge aclk) disable iff (!aresetn)
		start_wr && st_q.state == SGDC_IDLE |=> st_q.remain == $past(st_q.total);
	endproperty
	a_start: assert property (p_start) else $error("total not loaded at start");

	property p_ptr_hold;
		@(posedge aclk) disable iff (!aresetn)
		st_q.state == SGDC_RUN && !hits_zero |=> $stable(st_q.fetch_ptr);
	endproperty
	a_ptr_hold: assert property (p_ptr_hold) else $error("pointer sampled mid chain");

	property p_ro_write;
		@(posedge aclk) disable iff (!aresetn)
		do_write
		&& (st_q.aw_addr == SGDC_ADDR_REMAIN_LO || st_q.aw_addr == SGDC_ADDR_REMAIN_HI)
		&& !(fifo_valid && fifo_ready) |=> $stable(st_q.remain);
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("remaining count written");

	property p_read_remain;
		@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && s_axi_araddr == SGDC_ADDR_REMAIN_HI
		|=> s_axi_rvalid && s_axi_rdata == $past(st_q.remain[63:32]);
	endproperty
	a_read_remain: assert property (p_read_remain) else $error("bad remaining read");

	property p_desc_write;
		@(posedge aclk) disable iff (!aresetn)
		do_write && st_q.aw_addr == SGDC_ADDR_DESC_LO && st_q.wstrb == 4'hF
		|=> st_q.desc_ptr[31:0] == $past(st_q.wdata);
	endproperty
	a_desc_write: assert property (p_desc_write) else $error("pointer not written");

	property p_dir;
		@(posedge aclk) disable iff (!aresetn)
		do_write && st_q.aw_addr == SGDC_ADDR_CTRL && st_q.wstrb[0] && st_q.wstrb[2]
		|=> dma_dir_read == $past(st_q.wdata[SGDC_CTRL_DIR_BIT])
			&& dma_chain == $past(st_q.wdata[SGDC_CTRL_CHAIN_BIT]);
	endproperty
	a_dir: assert property (p_dir) else $error("mode outputs wrong");
endmodule

// ==== sgdc_pkg.sv ====
/*
 * sgdc_pkg: constants, types and register map of the chain counter.
 * assumes: included before every other design file.
 */
package sgdc_pkg;

	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [7:0] SGDC_ADDR_DESC_LO   = 8'h00;
	localparam logic [7:0] SGDC_ADDR_DESC_HI   = 8'h04;
	localparam logic [7:0] SGDC_ADDR_TOTAL_LO  = 8'h08;
	localparam logic [7:0] SGDC_ADDR_TOTAL_HI  = 8'h0C;
	localparam logic [7:0] SGDC_ADDR_REMAIN_LO = 8'h10;
	localparam logic [7:0] SGDC_ADDR_REMAIN_HI = 8'h14;
	localparam logic [7:0] SGDC_ADDR_CTRL      = 8'h18;
	localparam logic [7:0] SGDC_ADDR_STATUS    = 8'h1C;

	// ****************************************
	// control fields
	// ****************************************
	localparam int SGDC_CTRL_AUTO_BIT  = 0;
	localparam int SGDC_CTRL_DIR_BIT   = 2;
	localparam int SGDC_CTRL_CHAIN_BIT = 19;
	localparam int SGDC_CTRL_START_BIT = 31;

	localparam logic [1:0] SGDC_RESP_OKAY   = 2'h0;
	localparam logic [1:0] SGDC_RESP_SLVERR = 2'h2;
	localparam logic [31:0] SGDC_ZERO32     = 32'h0;
	localparam logic [63:0] SGDC_ZERO64     = 64'h0;

	localparam int SGDC_XFER_W = 32;
	localparam int SGDC_FIFO_DEPTH = 16;

	typedef enum logic [1:0] {SGDC_IDLE, SGDC_RUN, SGDC_FETCH} sgdc_state_e;

	// one transfer record: byte count consumed by this transfer
	typedef struct packed {
		logic [SGDC_XFER_W-1:0] bytes;
	} sgdc_xfer_s;

endpackage

// ==== sgdc_fifo.sv ====
/*
 * sgdc_fifo: synchronous valid/ready fifo.
 * assumes: single clock, synchronous active-low reset.
 */
module sgdc_fifo
	import sgdc_pkg::*;
#(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
		logic          rdy;
	} sgdc_fifo_s;

	logic [WIDTH-1:0] mem [DEPTH];
	sgdc_fifo_s       st_q;
	sgdc_fifo_s       st_d;
	logic             push;
	logic             pop;

	assign in_ready  = st_q.rdy;
	assign out_valid = (st_q.cnt != '0);
	assign out_data  = mem[st_q.rp];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		st_d = st_q;
		if (push)
			st_d.wp = (st_q.wp == AW'(DEPTH-1)) ? '0 : st_q.wp + 1'b1;
		if (pop)
			st_d.rp = (st_q.rp == AW'(DEPTH-1)) ? '0 : st_q.rp + 1'b1;
		st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
		// ready is registered so the top output comes from a flop
		st_d.rdy = (st_d.cnt != (AW+1)'(DEPTH));
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q     <= '0;
			st_q.rdy <= 1'b1;
		end else begin
			st_q <= st_d;
		end
		if (push)
			mem[st_q.wp] <= in_data;
	end

	// ****************************************
	// checks
	// ****************************************
	property p_no_overflow;
		@(posedge aclk) disable iff (!aresetn)
		st_q.cnt == (AW+1)'(DEPTH) |-> !in_ready;
	endproperty
	a_no_overflow: assert property (p_no_overflow) else $error("fifo full but ready");
endmodule

// ==== sgdc_host_model.sv ====
/* sgdc_host_model: host memory side answering descriptor fetches.
   assumes: fetch_req is a level held until one fetch_ack pulse is seen. */
module sgdc_host_model (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        fetch_req,
	input  wire logic [63:0] fetch_addr,
	input  wire logic [3:0]  delay,
	output logic             fetch_ack,
	output logic [63:0]      last_addr,
	output int               n_fetch
);
	logic [3:0] wait_q;

	// delay sets how many cycles memory stalls before answering
	always @(posedge aclk) begin
		if (!aresetn) begin
			fetch_ack <= 1'b0;
			wait_q    <= 4'h0;
			n_fetch   <= 0;
		end else if (fetch_ack || !fetch_req) begin
			fetch_ack <= 1'b0;
			wait_q    <= 4'h0;
		end else if (wait_q >= delay) begin
			fetch_ack <= 1'b1;
			last_addr <= fetch_addr;
			n_fetch   <= n_fetch + 1;
		end else begin
			wait_q <= wait_q + 4'h1;
		end
	end
endmodule

// ==== sgdc_top_tb.sv ====
/* sgdc_top_tb: self-checking bench of the chain byte counter.
   assumes: sgdc_pkg, sgdc_fifo, sgdc_top and sgdc_host_model compiled first. */
module sgdc_top_tb
	import sgdc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic         aclk = 1'b0;
	logic         aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic         s_axi_rready, xfer_valid, xfer_ready, fetch_req, fetch_ack;
	logic         dma_active, dma_dir_read, dma_chain;
	logic [1:0]   s_axi_bresp, s_axi_rresp, resp, mode;
	logic [3:0]   s_axi_wstrb, host_delay;
	logic [7:0]   s_axi_awaddr, s_axi_araddr;
	logic [31:0]  s_axi_wdata, s_axi_rdata, rd, b;
	logic [63:0]  fetch_addr, fetch_seen, ptr, total, rem;
	logic [127:0] words;
	sgdc_xfer_s   xfer_data;
	int           error_cnt = 0;
	int           n_compared = 0;
	int           n_fetch;

	sgdc_top #(.FIFO_DEPTH(SGDC_FIFO_DEPTH)) dut_u (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .xfer_data, .xfer_valid, .xfer_ready,
		.fetch_req, .fetch_addr, .fetch_ack, .dma_active, .dma_dir_read, .dma_chain
	);
	sgdc_host_model host_u (
		.aclk, .aresetn, .fetch_req, .fetch_addr, .delay(host_delay), .fetch_ack,
		.last_addr(fetch_seen), .n_fetch
	);

	always #5ns aclk = ~aclk;

	// ****************************************
	// bus tasks and expectations
	// ****************************************
	task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic tally_and_finish;
		$display("compared %0d mismatched %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		resp = s_axi_bresp;
	endtask

	task automatic axi_rd(input logic [7:0] a);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rd = s_axi_rdata;
		resp = s_axi_rresp;
	endtask

	// valid stays up; the caller drops it after the last item
	task automatic push(input logic [31:0] bytes);
		xfer_data  <= sgdc_xfer_s'(bytes);
		xfer_valid <= 1'b1;
		do
			@(posedge aclk);
		while (!xfer_ready);
	endtask

	function automatic logic [63:0] next_rem(input logic [63:0] r, input logic [31:0] x,
		input logic [63:0] t);
		return ({32'h0, x} >= r) ? t : r - {32'h0, x};
	endfunction

	function automatic logic [31:0] ctrl_word(input logic [1:0] m);
		return 32'h8000_0001 | (32'(m[0]) << SGDC_CTRL_DIR_BIT)
			| (32'(m[1]) << SGDC_CTRL_CHAIN_BIT);
	endfunction

	// polls until the count settles, the fifo drains one item a cycle
	task automatic check_rem(input logic [63:0] exp);
		logic [63:0] got;
		int          n;
		n = 0;
		do begin
			axi_rd(SGDC_ADDR_REMAIN_LO);
			got[31:0] = rd;
			axi_rd(SGDC_ADDR_REMAIN_HI);
			got[63:32] = rd;
			n++;
		end while (got !== exp && n < 40);
		check("remaining", exp, got);
	endtask

	task automatic start(input logic [1:0] m);
		axi_wr(SGDC_ADDR_CTRL, ctrl_word(m));
		check("direction", m[0], dma_dir_read);
		check("chaining", m[1], dma_chain);
	endtask

	task automatic wait_fetch(input int k);
		for (int i = 0; i < 40 && n_fetch < k; i++)
			@(posedge aclk);
		check("fetch count", k, n_fetch);
		check("fetch address", ptr, fetch_seen);
	endtask

	// ****************************************
	// tests
	// ****************************************
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, xfer_valid} = '0;
		// response readies stay high so no task lowers and raises them in one step
		{s_axi_bready, s_axi_rready} = 2'h3;
		host_delay = 4'h0;
		xfer_data = '0;
		s_axi_wstrb = 4'hF;
		void'($urandom(41));
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 0; i < 6; i++) begin
			axi_rd(8'(4 * i));
			check("reset value", 0, rd);
		end
		axi_rd(8'h20);
		check("unmapped response", SGDC_RESP_SLVERR, resp);
		axi_wr(8'h20, $urandom);
		check("unmapped write response", SGDC_RESP_SLVERR, resp);
		ptr = {$urandom, $urandom};
		total = {32'h1, 32'h1000 + $urandom_range(255)};
		words = {total, ptr};
		for (int i = 0; i < 4; i++) begin
			axi_wr(8'(4 * i), words[32 * i +: 32]);
			axi_rd(8'(4 * i));
			check("written word", words[32 * i +: 32], rd);
		end
		axi_wr(SGDC_ADDR_REMAIN_LO, $urandom);
		check("remaining write response", SGDC_RESP_OKAY, resp);
		axi_rd(SGDC_ADDR_REMAIN_LO);
		check("remaining after write", 0, rd);
		rem = total;
		for (int i = 0; i < SGDC_FIFO_DEPTH; i++) begin
			b = $urandom_range(255, 1);
			push(b);
			rem = next_rem(rem, b, total);
		end
		xfer_valid <= 1'b0;
		@(posedge aclk);
		#1 check("fifo full", 0, xfer_ready);
		host_delay <= 4'h7;
		mode = 2'($urandom);
		start(mode);
		wait_fetch(1);
		check_rem(rem);
		ptr = {$urandom, $urandom};
		axi_wr(SGDC_ADDR_DESC_LO, ptr[31:0]);
		axi_wr(SGDC_ADDR_DESC_HI, ptr[63:32]);
		check("pointer held", fetch_seen, fetch_addr);
		s_axi_wstrb <= 4'h1;
		axi_wr(SGDC_ADDR_TOTAL_HI, 32'hFFFF_FF00);
		s_axi_wstrb <= 4'hF;
		axi_rd(SGDC_ADDR_TOTAL_HI);
		check("strobed write", 0, rd);
		axi_wr(SGDC_ADDR_TOTAL_LO, 32'h200);
		host_delay <= 4'h0;
		push(32'hFFFF_FFFF);
		xfer_valid <= 1'b0;
		rem = next_rem(rem, 32'hFFFF_FFFF, 64'h200);
		check_rem(rem);
		push(rem[31:0] + $urandom_range(3));
		xfer_valid <= 1'b0;
		wait_fetch(2);
		check_rem(64'h200);
		axi_rd(SGDC_ADDR_STATUS);
		check("status running", 1, rd);
		axi_wr(SGDC_ADDR_CTRL, 0);
		for (int i = 1; i >= 0; i--) begin
			push(32'h100);
			xfer_valid <= 1'b0;
			check_rem(64'h100 << (1 - i));
		end
		repeat (20) @(posedge aclk);
		check("fetch count stopped", 2, n_fetch);
		check("engine active", 0, dma_active);
		start(~mode);
		wait_fetch(3);
		check_rem(64'h200);
		tally_and_finish;
	end

	initial begin
		#200us;
		error_cnt++;
		$display("BAD watchdog expected finish seen timeout");
		tally_and_finish;
	end
endmodule
